// *** src/dbm_pkg.sv ***
// constants shared by the debug block-memory command executor
package dbm_pkg;
    localparam int          LINK_BITS   = 17;
    localparam logic [4:0]  LAST_BIT    = 5'h10;
    localparam int          FIFO_WIDTH  = 16;
    localparam int          FIFO_DEPTH  = 16;

    // command word fields: opcode in 15:8, size in 7:4, zero in 3:0
    localparam logic [7:0]  OP_WRITE    = 8'h18;
    localparam logic [7:0]  OP_READ     = 8'h19;
    localparam logic [7:0]  OP_FILL     = 8'h1C;
    localparam logic [7:0]  OP_DUMP     = 8'h1D;
    localparam logic [7:0]  OP_RESUME   = 8'h0C;
    localparam logic [7:0]  OP_NOP      = 8'h00;
    localparam logic [3:0]  SZ_BYTE     = 4'h0;
    localparam logic [3:0]  SZ_WORD     = 4'h4;
    localparam logic [3:0]  SZ_LONG     = 4'h8;
    localparam logic [3:0]  LOW_ZERO    = 4'h0;

    // encoded access size on the core bus
    localparam logic [1:0]  ACC_BYTE    = 2'h0;
    localparam logic [1:0]  ACC_WORD    = 2'h1;
    localparam logic [1:0]  ACC_LONG    = 2'h2;

    // responses: status flag in bit 16, data in 15:0
    localparam logic [16:0] RSP_DONE    = 17'h0FFFF;
    localparam logic [16:0] RSP_BUS_FAULT_RESPONSE    = 17'h10001;
    localparam logic [16:0] RSP_NREADY  = 17'h10000;
    localparam logic [16:0] RSP_ILLEGAL = 17'h1FFFF;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_AHI  = 7'h02,
        ST_ALO  = 7'h04,
        ST_DHI  = 7'h08,
        ST_DLO  = 7'h10,
        ST_BUS  = 7'h20,
        ST_RLO  = 7'h40
    } dbm_state_t;
endpackage

// *** src/dbm_fifo.sv ***
// word fifo between the serial receiver and the command engine
`timescale 1ns/1ps
module dbm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } dbm_fifo_state_t;

    dbm_fifo_state_t s;
    dbm_fifo_state_t next_s;
    logic            push;
    logic            pop;

    assign in_ready  = (s.cnt != DEPTH[AW:0]);
    assign out_valid = (s.cnt != '0);
    assign out_data  = s.mem[s.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr        = s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = s.rd + 1'b1;
        end
        next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    a_fifo_full_hold: assert property (@(posedge clk) disable iff (srst)
        !in_ready && !pop |=> !in_ready)
        else $error("fifo full flag dropped without a pop");
    a_fifo_count: assert property (@(posedge clk) disable iff (srst)
        push && !pop |=> s.cnt == $past(s.cnt) + 1'b1)
        else $error("fifo count did not follow a push");
endmodule

// *** src/dbm_engine.sv ***
// debug port command executor: memory write tail, block read/write, resume
`timescale 1ns/1ps
// Functional notes
// - write answers done, or bus error flagged
// - block read only after nop, read, block read
// - read stores address plus size; block read advances
// - block read uses stored address unchecked
// - nop keeps stored block address
// - size decoded afresh every block command
// - block read word 0x1 0xD size 0x0
// - block read result packing; bus error flagged
// - block write only after nop, write, block write
// - write stores address plus size; block write advances
// - block write word 0x1 0xC size 0x0
// - block write answers done or bus error
// - resume flushes pipeline, restarts at pc
// - resume uses registers changed while halted
// - resume ignored when core not halted
// - resume answers done on next shift
// - transfers during memory access get not ready
// - status flag set on illegal, busy, fault
// - word and longword addresses forced aligned
// - nop only answers done on next shift
module dbm_engine
    import dbm_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        LINK_CLK,
    input  wire logic        LINK_IN,
    output logic             LINK_OUT,
    input  wire logic        CPU_HALTED,
    output logic             CORE_RESUME,
    output logic             MEM_REQ,
    output logic             MEM_WRITE,
    output logic [1:0]       MEM_SIZE,
    output logic [31:0]      MEM_ADDR,
    output logic [31:0]      MEM_WDATA,
    input  wire logic [31:0] MEM_RDATA,
    input  wire logic        MEM_ACK,
    input  wire logic        MEM_FAULT
);
    typedef struct packed {
        logic        lclk_s1;
        logic        lclk_s2;
        logic        lclk_s3;
        logic        din_s1;
        logic        din_s2;
        logic [4:0]  bit_cnt;
        logic [15:0] rx_shift;
        logic [15:0] rx_hold;
        logic        rx_hold_v;
        logic [16:0] tx_shift;
        logic [16:0] tx_word;
        logic [15:0] res_lo;
        dbm_state_t  state;
        logic        cmd_write;
        logic        cmd_block;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] blk_addr;
        logic        rd_ok;
        logic        wr_ok;
        logic        resume;
        logic        lo_sent;
    } dbm_state_s_t;

    dbm_state_s_t s;
    dbm_state_s_t next_s;
    logic         fifo_in_ready;
    logic         fifo_out_valid;
    logic         fifo_out_ready;
    logic [15:0]  fifo_out_data;
    logic         link_rise;
    logic         tx_taken;
    logic         cmd_pop;
    logic         size_ok;
    logic [1:0]   size_enc;

    // size nibble to bus size; anything else is not a legal size
    function automatic logic [2:0] decode_size(input logic [3:0] nib);
        case (nib)
            SZ_BYTE: decode_size = {1'b1, ACC_BYTE};
            SZ_WORD: decode_size = {1'b1, ACC_WORD};
            SZ_LONG: decode_size = {1'b1, ACC_LONG};
            default: decode_size = {1'b0, ACC_BYTE};
        endcase
    endfunction

    function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
        case (sz)
            ACC_WORD: align = {a[31:1], 1'b0};
            ACC_LONG: align = {a[31:2], 2'b00};
            default:  align = a;
        endcase
    endfunction

    function automatic logic [31:0] step(input logic [1:0] sz);
        case (sz)
            ACC_WORD: step = 32'h0000_0002;
            ACC_LONG: step = 32'h0000_0004;
            default:  step = 32'h0000_0001;
        endcase
    endfunction

    function automatic logic is_cmd(input logic [15:0] w, input logic [7:0] op);
        is_cmd = (w[15:8] == op) && (w[3:0] == LOW_ZERO);
    endfunction

    dbm_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .srst      (SRST),
        .in_valid  (s.rx_hold_v),
        .in_ready  (fifo_in_ready),
        .in_data   (s.rx_hold),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign link_rise      = s.lclk_s2 && !s.lclk_s3;
    assign tx_taken       = link_rise && (s.bit_cnt == '0);
    assign fifo_out_ready = (s.state == ST_IDLE) || (s.state == ST_AHI) ||
                            (s.state == ST_ALO) || (s.state == ST_DHI) ||
                            (s.state == ST_DLO) || (s.state == ST_RLO && s.lo_sent);
    assign cmd_pop        = fifo_out_valid && (s.state == ST_IDLE);
    assign {size_ok, size_enc} = decode_size(fifo_out_data[7:4]);

    assign LINK_OUT    = s.tx_shift[16];
    assign CORE_RESUME = s.resume;
    assign MEM_REQ     = (s.state == ST_BUS);
    assign MEM_WRITE   = s.cmd_write;
    assign MEM_SIZE    = s.size;
    assign MEM_ADDR    = s.addr;
    assign MEM_WDATA   = s.data;

    always_comb begin
        next_s         = s;
        next_s.lclk_s1 = LINK_CLK;
        next_s.lclk_s2 = s.lclk_s1;
        next_s.lclk_s3 = s.lclk_s2;
        next_s.din_s1  = LINK_IN;
        next_s.din_s2  = s.din_s1;
        next_s.resume  = 1'b0;

        // receiver: 17 bits a frame, the low 16 are the word
        if (s.rx_hold_v && fifo_in_ready) begin
            next_s.rx_hold_v = 1'b0;
        end
        if (link_rise) begin
            next_s.rx_shift = {s.rx_shift[14:0], s.din_s2};
            next_s.tx_shift = {s.tx_shift[15:0], 1'b0};
            if (s.bit_cnt == LAST_BIT) begin
                next_s.bit_cnt   = '0;
                next_s.rx_hold   = {s.rx_shift[14:0], s.din_s2};
                next_s.rx_hold_v = 1'b1;
            end else begin
                next_s.bit_cnt = s.bit_cnt + 5'h01;
            end
        end else if (s.bit_cnt == '0) begin
            next_s.tx_shift = s.tx_word;
        end
        // a response is sent once; later frames see not ready until replaced
        if (tx_taken) begin
            next_s.tx_word = RSP_NREADY;
        end

        case (s.state)
            ST_IDLE: begin
                if (cmd_pop) begin
                    next_s.size = size_enc;
                    next_s.rd_ok = 1'b0;
                    next_s.wr_ok = 1'b0;
                    if (fifo_out_data == {OP_NOP, 8'h00}) begin
                        next_s.rd_ok   = s.rd_ok;
                        next_s.wr_ok   = s.wr_ok;
                        next_s.tx_word = RSP_DONE;
                    end else if (fifo_out_data == {OP_RESUME, 8'h00}) begin
                        next_s.resume  = CPU_HALTED;
                        next_s.tx_word = RSP_DONE;
                    end else if (size_ok && (is_cmd(fifo_out_data, OP_READ) ||
                                             is_cmd(fifo_out_data, OP_WRITE))) begin
                        next_s.cmd_write = fifo_out_data[8] == OP_WRITE[0];
                        next_s.cmd_block = 1'b0;
                        next_s.state     = ST_AHI;
                    end else if (size_ok && is_cmd(fifo_out_data, OP_DUMP) && s.rd_ok) begin
                        next_s.cmd_write = 1'b0;
                        next_s.cmd_block = 1'b1;
                        next_s.rd_ok     = 1'b1;
                        next_s.addr      = align(s.blk_addr, size_enc);
                        next_s.state     = ST_BUS;
                    end else if (size_ok && is_cmd(fifo_out_data, OP_FILL) && s.wr_ok) begin
                        next_s.cmd_write = 1'b1;
                        next_s.cmd_block = 1'b1;
                        next_s.wr_ok     = 1'b1;
                        next_s.addr      = align(s.blk_addr, size_enc);
                        next_s.state     = (size_enc == ACC_LONG) ? ST_DHI : ST_DLO;
                    end else begin
                        next_s.tx_word = RSP_ILLEGAL;
                    end
                end
            end
            ST_AHI: begin
                if (fifo_out_valid) begin
                    next_s.addr[31:16] = fifo_out_data;
                    next_s.state       = ST_ALO;
                end
            end
            ST_ALO: begin
                if (fifo_out_valid) begin
                    next_s.addr = align({s.addr[31:16], fifo_out_data}, s.size);
                    if (!s.cmd_write) begin
                        next_s.state = ST_BUS;
                    end else if (s.size == ACC_LONG) begin
                        next_s.state = ST_DHI;
                    end else begin
                        next_s.state = ST_DLO;
                    end
                end
            end
            ST_DHI: begin
                if (fifo_out_valid) begin
                    next_s.data[31:16] = fifo_out_data;
                    next_s.state       = ST_DLO;
                end
            end
            ST_DLO: begin
                if (fifo_out_valid) begin
                    // byte data sits right-justified in the low byte
                    case (s.size)
                        ACC_BYTE: next_s.data = {24'h000000, fifo_out_data[7:0]};
                        ACC_WORD: next_s.data = {16'h0000, fifo_out_data};
                        default:  next_s.data = {s.data[31:16], fifo_out_data};
                    endcase
                    next_s.state = ST_BUS;
                end
            end
            ST_BUS: begin
                if (MEM_ACK) begin
                    next_s.state = ST_IDLE;
                    if (MEM_FAULT) begin
                        next_s.tx_word = RSP_BUS_FAULT_RESPONSE;
                        next_s.rd_ok   = 1'b0;
                        next_s.wr_ok   = 1'b0;
                    end else begin
                        next_s.blk_addr = s.addr + step(s.size);
                        next_s.rd_ok    = !s.cmd_write;
                        next_s.wr_ok    = s.cmd_write;
                        if (s.cmd_write) begin
                            next_s.tx_word = RSP_DONE;
                        end else begin
                            case (s.size)
                                ACC_BYTE: next_s.tx_word = {1'b0, 8'h00, MEM_RDATA[7:0]};
                                ACC_WORD: next_s.tx_word = {1'b0, MEM_RDATA[15:0]};
                                default:  next_s.tx_word = {1'b0, MEM_RDATA[31:16]};
                            endcase
                            next_s.res_lo = MEM_RDATA[15:0];
                            if (s.size == ACC_LONG) begin
                                next_s.state = ST_RLO;
                            end
                        end
                    end
                end
            end
            ST_RLO: begin
                // low half goes out in the frame after the high half; the word carried with the high half
                // is a filler and is dropped, the next command rides the frame carrying the low half
                if (tx_taken && !s.lo_sent) begin
                    next_s.tx_word = {1'b0, s.res_lo};
                    next_s.lo_sent = 1'b1;
                end
                if (s.lo_sent && fifo_out_valid) begin
                    next_s.lo_sent = 1'b0;
                    next_s.state   = ST_IDLE;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s          <= '0;
            s.state    <= ST_IDLE;
            s.tx_word  <= RSP_NREADY;
            s.tx_shift <= RSP_NREADY;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_bus_ok;
        MEM_REQ && MEM_ACK && !MEM_FAULT;
    endsequence
    sequence s_bus_fault;
        MEM_REQ && MEM_ACK && MEM_FAULT;
    endsequence

    a_busy_not_ready: assert property (MEM_REQ |-> s.tx_word == RSP_NREADY)
        else $error("response not held at not ready during access");
    a_write_done: assert property (s_bus_ok ##0 MEM_WRITE |=> s.tx_word == RSP_DONE)
        else $error("write completion answer wrong");
    a_fault_answer: assert property (s_bus_fault |=> s.tx_word == RSP_BUS_FAULT_RESPONSE)
        else $error("bus fault answer wrong");
    a_dump_illegal: assert property (cmd_pop && is_cmd(fifo_out_data, OP_DUMP) && !s.rd_ok
        |=> s.tx_word == RSP_ILLEGAL && !MEM_REQ)
        else $error("block read without prior read not refused");
    a_fill_illegal: assert property (cmd_pop && is_cmd(fifo_out_data, OP_FILL) && !s.wr_ok
        |=> s.tx_word == RSP_ILLEGAL)
        else $error("block write without prior write not refused");
    a_addr_step: assert property (s_bus_ok
        |=> s.blk_addr == $past(MEM_ADDR) + step($past(MEM_SIZE)))
        else $error("stored block address not advanced by size");
    a_nop_keeps: assert property (cmd_pop && fifo_out_data == {OP_NOP, 8'h00}
        |=> s.blk_addr == $past(s.blk_addr) && s.tx_word == RSP_DONE)
        else $error("nop disturbed the block address");
    a_addr_align: assert property (MEM_REQ && MEM_SIZE != ACC_BYTE
        |-> MEM_ADDR[0] == 1'b0 && (MEM_SIZE != ACC_LONG || MEM_ADDR[1] == 1'b0))
        else $error("misaligned word or longword access");
    a_resume_halted: assert property (CORE_RESUME |-> $past(CPU_HALTED))
        else $error("resume issued while core running");
    a_long_split: assert property (s.state == ST_RLO && tx_taken && !s.lo_sent
        |=> s.tx_word == {1'b0, $past(s.res_lo)})
        else $error("second longword half not returned");
endmodule

// *** testbench/dbm_host.sv ***
// host model: shifts 17-bit frames over the serial link, link clock stands still between frames
`timescale 1ns/1ps
module dbm_host (
    input  wire logic clk,
    output logic      link_clk,
    output logic      link_in,
    input  wire logic link_out
);
    initial begin
        link_clk = 1'b0;
        link_in  = 1'b1;
    end

    // each bit lasts 8 system cycles (400 ns); the response bit is taken just before the rise
    task automatic frame(input logic [15:0] w, output logic [16:0] r);
        logic [16:0] sh;
        sh = {1'b0, w};
        for (int i = 16; i >= 0; i--) begin
            @(posedge clk);
            link_clk <= 1'b0;
            link_in  <= sh[i];
            repeat (3) @(posedge clk);
            @(negedge clk);
            r[i] = link_out;
            @(posedge clk);
            link_clk <= 1'b1;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        link_clk <= 1'b0;
        // released data line shows the inverse so a stale bit cannot pass for a good one
        link_in  <= ~sh[0];
        repeat (12) @(posedge clk);
    endtask
endmodule

// *** testbench/test_dbm_engine.sv ***
// self-checking bench for the debug block-memory command executor
`timescale 1ns/1ps
module test_dbm_engine;
    import dbm_pkg::*;
    localparam int LIMIT = 20000;
    localparam logic [16:0] NR = RSP_NREADY;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        link_clk;
    logic        link_in;
    logic        link_out;
    logic        cpu_halted = 1'b0;
    logic        core_resume;
    logic        mem_req;
    logic        mem_write;
    logic [1:0]  mem_size;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata = 32'h0;
    logic        mem_ack = 1'b0;
    logic        mem_fault = 1'b0;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          mem_dly = 1;
    int          wcnt = 0;
    int          acc_n = 0;
    int          res_n = 0;
    logic        fault_next = 1'b0;
    logic [31:0] acc_addr;
    logic [31:0] acc_wdata;
    logic [1:0]  acc_size;
    logic        acc_wr;

    dbm_engine dut (.CLK(clk), .SRST(srst), .LINK_CLK(link_clk), .LINK_IN(link_in),
        .LINK_OUT(link_out), .CPU_HALTED(cpu_halted), .CORE_RESUME(core_resume),
        .MEM_REQ(mem_req), .MEM_WRITE(mem_write), .MEM_SIZE(mem_size), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .MEM_FAULT(mem_fault));
    dbm_host host (.clk(clk), .link_clk(link_clk), .link_in(link_in), .link_out(link_out));

    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] rd_of(input logic [31:0] a);
        return {~a[15:0], a[15:0] ^ 16'h5A3C};
    endfunction

    // k: 2 high word, 1 low word, 0 byte with upper byte zero
    function automatic logic [16:0] rsp(input logic [31:0] a, input int k);
        logic [31:0] d;
        d = rd_of(a);
        if (k == 2) return {1'b0, d[31:16]};
        if (k == 1) return {1'b0, d[15:0]};
        return {9'h000, d[7:0]};
    endfunction

    // memory with programmable wait; idle read data keeps toggling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (core_resume === 1'b1) res_n <= res_n + 1;
        if (mem_req === 1'b1 && mem_ack === 1'b0) begin
            wcnt <= wcnt + 1;
            if (wcnt >= mem_dly) begin
                wcnt      <= 0;
                mem_ack   <= 1'b1;
                mem_fault <= fault_next;
                mem_rdata <= rd_of(mem_addr);
                acc_n     <= acc_n + 1;
                acc_addr  <= mem_addr;
                acc_size  <= mem_size;
                acc_wr    <= mem_write;
                acc_wdata <= mem_wdata;
            end
        end else begin
            mem_ack   <= 1'b0;
            mem_fault <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end

    task automatic test_done;
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (cyc == LIMIT) begin
            err_count++;
            $display("[ERR] %0t run did not finish", $time);
            test_done;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xf(input logic [15:0] w, input logic [16:0] exp, input bit chk);
        logic [16:0] r;
        host.frame(w, r);
        if (chk) check({15'h0, r}, {15'h0, exp});
    endtask

    task automatic acc(input int n, input logic [31:0] a, input logic [1:0] sz,
                       input logic wr, input logic [31:0] wd);
        check(acc_n, n);
        check(acc_addr, a);
        check({30'h0, acc_size}, {30'h0, sz});
        check({31'h0, acc_wr}, {31'h0, wr});
        if (wr) check(acc_wdata, wd);
    endtask

    task automatic s_write_fill;
        xf(16'h1840, NR, 0);
        xf(16'h0000, NR, 1);
        xf(16'h1003, NR, 1);
        xf(16'hBEEF, NR, 1);
        xf(16'h1C80, RSP_DONE, 1);
        acc(1, 32'h0000_1002, ACC_WORD, 1'b1, 32'h0000_BEEF);
        xf(16'h1234, NR, 1);
        xf(16'h5678, NR, 1);
        xf(16'h0000, RSP_DONE, 1);
        acc(2, 32'h0000_1004, ACC_LONG, 1'b1, 32'h1234_5678);
        xf(16'h1C00, RSP_DONE, 1);
        xf(16'h0077, NR, 1);
        xf(16'h1C40, RSP_DONE, 1);
        acc(3, 32'h0000_1008, ACC_BYTE, 1'b1, 32'h0000_0077);
        fault_next = 1'b1;
        xf(16'hCAFE, NR, 1);
        xf(16'h1C40, RSP_BUS_FAULT_RESPONSE, 1);
        fault_next = 1'b0;
        acc(4, 32'h0000_1008, ACC_WORD, 1'b1, 32'h0000_CAFE);
        xf(16'h0000, RSP_ILLEGAL, 1);
        check(acc_n, 4);
    endtask

    task automatic s_read_dump;
        int n0;
        n0 = acc_n;
        xf(16'h1D40, RSP_DONE, 0);
        xf(16'h1D41, RSP_ILLEGAL, 1);
        xf(16'h0000, RSP_ILLEGAL, 1);
        xf(16'h1980, RSP_DONE, 1);
        xf(16'h0000, NR, 1);
        xf(16'h2002, NR, 1);
        xf(16'h0000, rsp(32'h2000, 2), 1);
        xf(16'h1D40, rsp(32'h2000, 1), 1);
        acc(n0 + 2, 32'h0000_2004, ACC_WORD, 1'b0, 32'h0);
        xf(16'h1D00, rsp(32'h2004, 1), 1);
        xf(16'h0000, rsp(32'h2006, 0), 1);
        acc(n0 + 3, 32'h0000_2006, ACC_BYTE, 1'b0, 32'h0);
        fault_next = 1'b1;
        xf(16'h1D40, RSP_DONE, 1);
        xf(16'h0000, RSP_BUS_FAULT_RESPONSE, 1);
        fault_next = 1'b0;
        acc(n0 + 4, 32'h0000_2006, ACC_WORD, 1'b0, 32'h0);
    endtask

    task automatic s_busy;
        int n0;
        n0 = acc_n;
        mem_dly = 250;
        xf(16'h1800, NR, 0);
        xf(16'h0000, NR, 1);
        xf(16'h3001, NR, 1);
        xf(16'h00AB, NR, 1);
        xf(16'h0000, NR, 1);
        for (int i = 0; i < 400 && acc_n == n0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        xf(16'h0000, RSP_DONE, 1);
        acc(n0 + 1, 32'h0000_3001, ACC_BYTE, 1'b1, 32'h0000_00AB);
        mem_dly = 1;
    endtask

    task automatic s_resume;
        int r0;
        @(posedge clk);
        cpu_halted <= 1'b1;
        r0 = res_n;
        xf(16'h0C00, RSP_DONE, 0);
        xf(16'h0000, RSP_DONE, 1);
        check(res_n, r0 + 1);
        @(posedge clk);
        cpu_halted <= 1'b0;
        xf(16'h0C00, RSP_DONE, 0);
        xf(16'h0000, RSP_DONE, 0);
        check(res_n, r0 + 1);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        s_write_fill();
        s_read_dump();
        s_busy();
        s_resume();
        test_done();
    end
endmodule
